// ==== core/bctr_pkg.sv ====
package bctr_pkg;

  // Register addresses, seven bits wide
  localparam logic [6:0] A_INT_CFG = 7'h0b;
  localparam logic [6:0] A_THS_L = 7'h0c;
  localparam logic [6:0] A_THS_H = 7'h0d;
  localparam logic [6:0] A_WHO = 7'h0f;
  localparam logic [6:0] A_CTRL1 = 7'h10;
  localparam logic [6:0] A_CTRL2 = 7'h11;
  localparam logic [6:0] A_REF_XL = 7'h15;
  localparam logic [6:0] A_REF_L = 7'h16;
  localparam logic [6:0] A_REF_H = 7'h17;
  localparam logic [6:0] A_OFS_L = 7'h18;
  localparam logic [6:0] A_OFS_H = 7'h19;
  localparam logic [6:0] A_INT_SRC = 7'h25;
  localparam logic [6:0] A_P_XL = 7'h28;
  localparam logic [6:0] A_P_L = 7'h29;
  localparam logic [6:0] A_P_H = 7'h2a;
  localparam logic [6:0] A_T_L = 7'h2b;
  localparam logic [6:0] A_T_H = 7'h2c;

  // Threshold interrupt and reference mode configuration fields
  localparam int B_HIGH_EN = 0;
  localparam int B_LOW_EN = 1;
  localparam int B_LATCH = 2;
  localparam int B_THR_EN = 3;
  localparam int B_ZERO_CLR = 4;
  localparam int B_ZERO_EN = 5;
  localparam int B_IREF_CLR = 6;
  localparam int B_IREF_EN = 7;
  localparam logic [7:0] INT_CFG_WMASK = 8'haf;

  // Serial mode, freeze, filter and rate control fields
  localparam int B_3WIRE = 0;
  localparam int B_FREEZE = 1;
  localparam int B_BW_SEL = 2;
  localparam int B_LPF_EN = 3;
  localparam int F_RATE_LSB = 4;
  localparam logic [7:0] CTRL1_WMASK = 8'h7f;

  // System control fields
  localparam int B_ONE_SHOT = 0;
  localparam int B_SOFT_RST = 2;
  localparam int B_BOOT = 7;
  localparam logic [7:0] CTRL2_WMASK = 8'hf9;

  // Interrupt source fields
  localparam int B_SRC_HIGH = 0;
  localparam int B_SRC_LOW = 1;
  localparam int B_SRC_ACTIVE = 2;

  localparam logic [7:0] RST_CFG = 8'h00;
  localparam logic [7:0] RST_CTRL = 8'h00;
  // Identity value is arbitrary
  localparam logic [7:0] ID_DEFAULT = 8'h5a;

  // Sample rate codes and frequencies
  localparam logic [2:0] RATE_OFF = 3'h0;
  localparam logic [2:0] RATE_1 = 3'h1;
  localparam logic [2:0] RATE_10 = 3'h2;
  localparam logic [2:0] RATE_25 = 3'h3;
  localparam logic [2:0] RATE_50 = 3'h4;
  localparam logic [2:0] RATE_75 = 3'h5;
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned CYC_1HZ = CLK_HZ / 1;
  localparam int unsigned CYC_10HZ = CLK_HZ / 10;
  localparam int unsigned CYC_25HZ = CLK_HZ / 25;
  localparam int unsigned CYC_50HZ = CLK_HZ / 50;
  localparam int unsigned CYC_75HZ = CLK_HZ / 75;
  localparam int CNT_W = 24;

  // Bandwidth divisors of the sample rate
  localparam logic [4:0] BW_DIV_OPEN = 5'h02;
  localparam logic [4:0] BW_DIV_MID = 5'h09;
  localparam logic [4:0] BW_DIV_NARROW = 5'h14;

  // Pressure counts per threshold count, as a shift
  localparam int THS_SHIFT = 8;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_CONV = 2'b10
  } bctr_acq_e;

endpackage

// ==== core/bctr_cmp_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface bctr_cmp_if;
  logic sample_valid;
  logic signed [24:0] compare_input;
  logic [15:0] threshold;
  logic result_valid;
  logic high_event;
  logic low_event;

  modport ctrl (
    output sample_valid, compare_input, threshold,
    input result_valid, high_event, low_event
  );
  modport cmp (
    input sample_valid, compare_input, threshold,
    output result_valid, high_event, low_event
  );
endinterface
`default_nettype wire

// ==== core/bctr_rate_timer.sv ====
`timescale 1ns/1ps
`default_nettype none
module bctr_rate_timer #(
  parameter int unsigned CYC_1 = bctr_pkg::CYC_1HZ,
  parameter int unsigned CYC_10 = bctr_pkg::CYC_10HZ,
  parameter int unsigned CYC_25 = bctr_pkg::CYC_25HZ,
  parameter int unsigned CYC_50 = bctr_pkg::CYC_50HZ,
  parameter int unsigned CYC_75 = bctr_pkg::CYC_75HZ
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // Rate code in, sample tick out
  input wire logic [2:0] i_rate,
  output logic o_tick
);
  typedef struct packed {
    logic [bctr_pkg::CNT_W-1:0] cnt;
    logic [2:0] rate;
    logic tick;
  } bctr_tmr_s;

  bctr_tmr_s s;
  bctr_tmr_s next_s;
  logic [bctr_pkg::CNT_W-1:0] period;

  if (CYC_75 < 2 || CYC_1 >= (1 << bctr_pkg::CNT_W)) begin : g_chk
    $error("rate periods out of range");
  end

  always_comb begin
    case (i_rate)
      bctr_pkg::RATE_1: period = bctr_pkg::CNT_W'(CYC_1);
      bctr_pkg::RATE_10: period = bctr_pkg::CNT_W'(CYC_10);
      bctr_pkg::RATE_25: period = bctr_pkg::CNT_W'(CYC_25);
      bctr_pkg::RATE_50: period = bctr_pkg::CNT_W'(CYC_50);
      default: period = bctr_pkg::CNT_W'(CYC_75);
    endcase
  end

  always_comb begin
    next_s = s;
    next_s.rate = i_rate;
    next_s.tick = 1'b0;
    // Restart the period whenever the rate changes
    if (i_rate == bctr_pkg::RATE_OFF || i_rate != s.rate) begin
      next_s.cnt = '0;
    end else if (s.cnt == period - 1'b1) begin
      next_s.cnt = '0;
      next_s.tick = 1'b1;
    end else begin
      next_s.cnt = s.cnt + 1'b1;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign o_tick = s.tick;
endmodule
`default_nettype wire

// ==== core/bctr_thresh_cmp.sv ====
`timescale 1ns/1ps
`default_nettype none
module bctr_thresh_cmp (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // Comparison request and result
  bctr_cmp_if.cmp bus
);
  typedef struct packed {
    logic valid;
    logic high;
    logic low;
  } bctr_cmp_s;

  bctr_cmp_s s;
  bctr_cmp_s next_s;
  logic signed [25:0] limit;
  logic signed [25:0] diff;

  always_comb begin
    limit = $signed({2'b00, bus.threshold, 8'h00}) >>> (8 - bctr_pkg::THS_SHIFT);
    diff = {bus.compare_input[24], bus.compare_input};
    next_s = s;
    next_s.valid = bus.sample_valid;
    if (bus.sample_valid) begin
      next_s.high = diff > limit;
      next_s.low = diff < -limit;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign bus.result_valid = s.valid;
  assign bus.high_event = s.high;
  assign bus.low_event = s.low;
endmodule
`default_nettype wire

// ==== core/bctr_regs.sv ====
`timescale 1ns/1ps
`default_nettype none
module bctr_regs #(
  parameter logic [7:0] IDENTITY = bctr_pkg::ID_DEFAULT,
  parameter int unsigned CYC_1 = bctr_pkg::CYC_1HZ,
  parameter int unsigned CYC_10 = bctr_pkg::CYC_10HZ,
  parameter int unsigned CYC_25 = bctr_pkg::CYC_25HZ,
  parameter int unsigned CYC_50 = bctr_pkg::CYC_50HZ,
  parameter int unsigned CYC_75 = bctr_pkg::CYC_75HZ
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // Register port from the serial front end
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [6:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  // Conversion handshake with the sensing chain
  output logic o_conv_start,
  input wire logic i_conv_done,
  input wire logic [23:0] i_meas_pressure,
  input wire logic [15:0] i_meas_temp,
  // Status and configuration outputs
  output logic o_irq_request,
  output logic o_power_down,
  output logic o_three_wire_select,
  output logic [4:0] o_bandwidth_div
);
  typedef struct packed {
    bctr_pkg::bctr_acq_e acq;
    logic [7:0] int_cfg;
    logic [15:0] pressure_threshold;
    logic [7:0] ctrl1;
    logic [7:0] ctrl2;
    logic [23:0] ref_p;
    logic [15:0] pressure_offset_value;
    logic zero_mode;
    logic iref_mode;
    logic [23:0] pressure_output;
    logic [15:0] temp_output;
    logic frozen;
    logic [2:0] int_src;
    logic conv_start;
    logic sample_valid;
    logic signed [24:0] compare_input;
    logic [7:0] rdata;
    logic power_down;
    logic [4:0] bw_div;
  } bctr_regs_s;

  // Reset image: idle, powered down, open bandwidth, all else zero
  localparam bctr_regs_s RST_S = '{
    acq: bctr_pkg::ST_IDLE,
    power_down: 1'b1,
    bw_div: bctr_pkg::BW_DIV_OPEN,
    default: '0
  };

  bctr_regs_s s;
  bctr_regs_s next_s;
  logic tick;
  logic [2:0] rate;
  logic hi;
  logic lo;
  logic [2:0] src_now;
  logic [23:0] ref_use;
  logic signed [24:0] rel;
  logic signed [24:0] ofs_diff;
  logic [7:0] rd;

  bctr_cmp_if cmp_bus ();

  // Slower codes need longer periods, else the rate order inverts
  if (CYC_10 > CYC_1 || CYC_25 > CYC_10 || CYC_50 > CYC_25 ||
      CYC_75 > CYC_50) begin : g_rate_chk
    $error("rate periods must shrink as the code rises");
  end

  // Comparator aligns the threshold with a right shift
  if (bctr_pkg::THS_SHIFT < 0 ||
      bctr_pkg::THS_SHIFT > 8) begin : g_shift_chk
    $error("threshold shift must lie in 0 to 8");
  end

  // An all-zero identity would read like an empty address
  if (IDENTITY == 8'h00) begin : g_id_chk
    $error("identity value must not be zero");
  end

  assign rate = s.ctrl1[bctr_pkg::F_RATE_LSB +: 3];

  bctr_rate_timer #(
    .CYC_1(CYC_1),
    .CYC_10(CYC_10),
    .CYC_25(CYC_25),
    .CYC_50(CYC_50),
    .CYC_75(CYC_75)
  ) u_timer (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_rate(rate),
    .o_tick(tick)
  );

  assign cmp_bus.sample_valid = s.sample_valid;
  assign cmp_bus.compare_input = s.compare_input;
  assign cmp_bus.threshold = s.pressure_threshold;

  bctr_thresh_cmp u_cmp (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .bus(cmp_bus)
  );

  always_comb begin
    case (i_reg_addr)
      bctr_pkg::A_INT_CFG: rd = s.int_cfg;
      bctr_pkg::A_THS_L: rd = s.pressure_threshold[7:0];
      bctr_pkg::A_THS_H: rd = s.pressure_threshold[15:8];
      bctr_pkg::A_WHO: rd = IDENTITY;
      bctr_pkg::A_CTRL1: rd = s.ctrl1;
      bctr_pkg::A_CTRL2: rd = s.ctrl2;
      bctr_pkg::A_REF_XL: rd = s.ref_p[7:0];
      bctr_pkg::A_REF_L: rd = s.ref_p[15:8];
      bctr_pkg::A_REF_H: rd = s.ref_p[23:16];
      bctr_pkg::A_OFS_L: rd = s.pressure_offset_value[7:0];
      bctr_pkg::A_OFS_H: rd = s.pressure_offset_value[15:8];
      bctr_pkg::A_INT_SRC: rd = {5'h00, s.int_src};
      bctr_pkg::A_P_XL: rd = s.pressure_output[7:0];
      bctr_pkg::A_P_L: rd = s.pressure_output[15:8];
      bctr_pkg::A_P_H: rd = s.pressure_output[23:16];
      bctr_pkg::A_T_L: rd = s.temp_output[7:0];
      bctr_pkg::A_T_H: rd = s.temp_output[15:8];
      default: rd = 8'h00;
    endcase
  end

  always_comb begin
    next_s = s;
    next_s.conv_start = 1'b0;
    next_s.sample_valid = 1'b0;
    hi = 1'b0;
    lo = 1'b0;
    src_now = 3'h0;
    ref_use = s.ref_p;
    rel = 25'sh0;
    ofs_diff = 25'sh0;
    // Boot has no memory to reload here, so it clears at once
    next_s.ctrl2[bctr_pkg::B_BOOT] = 1'b0;

    // Read side effects first, so hardware sets win
    if (i_reg_rd) begin
      next_s.rdata = rd;
      if (i_reg_addr == bctr_pkg::A_P_H) begin
        next_s.frozen = 1'b0;
      end
      if (i_reg_addr == bctr_pkg::A_INT_SRC &&
          s.int_cfg[bctr_pkg::B_LATCH]) begin
        next_s.int_src = 3'h0;
      end
    end

    case (s.acq)
      bctr_pkg::ST_IDLE: begin
        if (rate != bctr_pkg::RATE_OFF && tick) begin
          next_s.acq = bctr_pkg::ST_CONV;
          next_s.conv_start = 1'b1;
        end else if (rate == bctr_pkg::RATE_OFF &&
                     s.ctrl2[bctr_pkg::B_ONE_SHOT]) begin
          next_s.acq = bctr_pkg::ST_CONV;
          next_s.conv_start = 1'b1;
        end
      end
      // Ticks that land mid-conversion are dropped, not queued
      bctr_pkg::ST_CONV: begin
        if (i_conv_done) begin
          next_s.acq = bctr_pkg::ST_IDLE;
          next_s.ctrl2[bctr_pkg::B_ONE_SHOT] = 1'b0;
          if (s.int_cfg[bctr_pkg::B_ZERO_EN]) begin
            ref_use = i_meas_pressure;
            next_s.zero_mode = 1'b1;
            next_s.int_cfg[bctr_pkg::B_ZERO_EN] = 1'b0;
          end
          if (s.int_cfg[bctr_pkg::B_IREF_EN]) begin
            ref_use = i_meas_pressure;
            next_s.iref_mode = 1'b1;
            next_s.int_cfg[bctr_pkg::B_IREF_EN] = 1'b0;
          end
          next_s.ref_p = ref_use;
          rel = $signed({i_meas_pressure[23], i_meas_pressure}) -
                $signed({ref_use[23], ref_use});
          // Offset is signed, so it is sign-extended first
          ofs_diff = $signed({i_meas_pressure[23], i_meas_pressure}) -
                     $signed({{9{s.pressure_offset_value[15]}},
                              s.pressure_offset_value});
          if (next_s.zero_mode || next_s.iref_mode) begin
            next_s.compare_input = rel;
          end else begin
            next_s.compare_input = {i_meas_pressure[23], i_meas_pressure};
          end
          next_s.sample_valid = 1'b1;
          if (!(s.frozen && next_s.frozen)) begin
            if (next_s.zero_mode) begin
              next_s.pressure_output = rel[23:0];
            end else if (next_s.iref_mode) begin
              next_s.pressure_output = ofs_diff[23:0];
            end else begin
              next_s.pressure_output = i_meas_pressure;
            end
            next_s.temp_output = i_meas_temp;
            next_s.frozen = s.ctrl1[bctr_pkg::B_FREEZE];
          end
        end
      end
      default: next_s.acq = bctr_pkg::ST_IDLE;
    endcase

    if (cmp_bus.result_valid) begin
      hi = s.int_cfg[bctr_pkg::B_THR_EN] &
           s.int_cfg[bctr_pkg::B_HIGH_EN] & cmp_bus.high_event;
      lo = s.int_cfg[bctr_pkg::B_THR_EN] &
           s.int_cfg[bctr_pkg::B_LOW_EN] & cmp_bus.low_event;
      src_now[bctr_pkg::B_SRC_HIGH] = hi;
      src_now[bctr_pkg::B_SRC_LOW] = lo;
      src_now[bctr_pkg::B_SRC_ACTIVE] = hi | lo;
      if (s.int_cfg[bctr_pkg::B_LATCH]) begin
        next_s.int_src = next_s.int_src | src_now;
      end else begin
        next_s.int_src = src_now;
      end
    end

    // Host writes last, so they win over self-clearing
    if (i_reg_wr) begin
      case (i_reg_addr)
        bctr_pkg::A_INT_CFG: begin
          next_s.int_cfg = i_reg_wdata & bctr_pkg::INT_CFG_WMASK;
          if (i_reg_wdata[bctr_pkg::B_ZERO_CLR]) begin
            next_s.zero_mode = 1'b0;
            next_s.ref_p = 24'h000000;
          end
          if (i_reg_wdata[bctr_pkg::B_IREF_CLR]) begin
            next_s.iref_mode = 1'b0;
          end
        end
        bctr_pkg::A_THS_L: next_s.pressure_threshold[7:0] = i_reg_wdata;
        bctr_pkg::A_THS_H: next_s.pressure_threshold[15:8] = i_reg_wdata;
        bctr_pkg::A_CTRL1: next_s.ctrl1 = i_reg_wdata & bctr_pkg::CTRL1_WMASK;
        bctr_pkg::A_CTRL2: begin
          // Soft reset leaves offset and event flags alone
          if (i_reg_wdata[bctr_pkg::B_SOFT_RST]) begin
            next_s.int_cfg = bctr_pkg::RST_CFG;
            next_s.pressure_threshold = 16'h0000;
            next_s.ctrl1 = bctr_pkg::RST_CTRL;
            next_s.ctrl2 = bctr_pkg::RST_CTRL;
            next_s.ref_p = 24'h000000;
            next_s.zero_mode = 1'b0;
            next_s.iref_mode = 1'b0;
          end else begin
            next_s.ctrl2 = i_reg_wdata & bctr_pkg::CTRL2_WMASK;
          end
        end
        bctr_pkg::A_OFS_L: next_s.pressure_offset_value[7:0] = i_reg_wdata;
        bctr_pkg::A_OFS_H: next_s.pressure_offset_value[15:8] = i_reg_wdata;
        default: ;
      endcase
    end

    // idle with rate off is power-down
    next_s.power_down = (next_s.acq == bctr_pkg::ST_IDLE) &&
      (next_s.ctrl1[bctr_pkg::F_RATE_LSB +: 3] == bctr_pkg::RATE_OFF);
    if (!next_s.ctrl1[bctr_pkg::B_LPF_EN]) begin
      next_s.bw_div = bctr_pkg::BW_DIV_OPEN;
    end else if (!next_s.ctrl1[bctr_pkg::B_BW_SEL]) begin
      next_s.bw_div = bctr_pkg::BW_DIV_MID;
    end else begin
      next_s.bw_div = bctr_pkg::BW_DIV_NARROW;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s <= RST_S;
    end else begin
      s <= next_s;
    end
  end

  assign o_reg_rdata = s.rdata;
  assign o_conv_start = s.conv_start;
  assign o_irq_request = s.int_src[bctr_pkg::B_SRC_ACTIVE];
  assign o_power_down = s.power_down;
  assign o_three_wire_select = s.ctrl1[bctr_pkg::B_3WIRE];
  assign o_bandwidth_div = s.bw_div;
endmodule
`default_nettype wire

// ==== verif/bctr_regs_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
module bctr_regs_chk #(
  parameter logic [7:0] IDENTITY = bctr_pkg::ID_DEFAULT
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // Register port
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [6:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic [7:0] o_reg_rdata,
  // Conversion and status
  input wire logic o_conv_start,
  input wire logic i_conv_done,
  input wire logic o_irq_request,
  input wire logic o_power_down,
  input wire logic o_three_wire_select,
  input wire logic [4:0] o_bandwidth_div
);
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_rst_n);

  // A second start before done would lose a sample
  logic busy;
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      busy <= 1'b0;
    end else if (i_conv_done) begin
      busy <= 1'b0;
    end else if (o_conv_start) begin
      busy <= 1'b1;
    end
  end

  a_start_pulse: assert property (
    o_conv_start |=> !o_conv_start)
    else $error("conversion start longer than one cycle");
  a_start_single: assert property (
    o_conv_start |-> !busy)
    else $error("conversion started while one in flight");
  a_start_awake: assert property (
    o_conv_start |-> !o_power_down)
    else $error("power down flagged at conversion start");
  a_one_shot_go: assert property (
    i_reg_wr && i_reg_addr == bctr_pkg::A_CTRL2 && i_reg_wdata[0]
    && !i_reg_wdata[2] && o_power_down |-> ##2 o_conv_start)
    else $error("one-shot did not start a conversion");
  a_rd_hold: assert property (
    !$past(i_reg_rd) |-> $stable(o_reg_rdata))
    else $error("read data changed without a read");
  a_who_value: assert property (
    i_reg_rd && i_reg_addr == bctr_pkg::A_WHO |=> o_reg_rdata == IDENTITY)
    else $error("identity read wrong");
  a_unmapped_zero: assert property (
    i_reg_rd && i_reg_addr < 7'h0b |=> o_reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_irq_cause: assert property (
    $rose(o_irq_request) |-> $past(i_conv_done, 3))
    else $error("interrupt rose without a result");
  a_cfg_follow: assert property (
    (i_reg_wr && i_reg_addr == bctr_pkg::A_CTRL1) ##1 !i_reg_wr |=>
    o_three_wire_select == $past(i_reg_wdata[0], 2) &&
    o_bandwidth_div == (!$past(i_reg_wdata[3], 2) ? 5'h02 :
    ($past(i_reg_wdata[2], 2) ? 5'h14 : 5'h09)))
    else $error("serial mode or bandwidth wrong");

  c_conv: cover property (o_conv_start ##[1:20] i_conv_done);
  c_irq: cover property (i_conv_done ##3 o_irq_request);
  c_high_read: cover property (i_reg_rd && i_reg_addr == bctr_pkg::A_P_H);
endmodule

bind bctr_regs bctr_regs_chk #(.IDENTITY(IDENTITY)) chk_u (
  .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_reg_wr(i_reg_wr),
  .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr),
  .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
  .o_conv_start(o_conv_start), .i_conv_done(i_conv_done),
  .o_irq_request(o_irq_request), .o_power_down(o_power_down),
  .o_three_wire_select(o_three_wire_select),
  .o_bandwidth_div(o_bandwidth_div)
);
`default_nettype wire

// ==== verif/bctr_sense_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module bctr_sense_model #(
  parameter int DLY = 2
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // Conversion request and value to return
  input wire logic i_start,
  input wire logic [23:0] i_press,
  // Completion and results
  output logic o_done,
  output logic [23:0] o_press,
  output logic [15:0] o_temp
);
  int cnt;
  logic [23:0] last;
  // Inverted outside done so stale sampling shows up
  assign o_press = o_done ? last : ~last;
  assign o_temp = o_done ? last[23:8] : ~last[23:8];
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt <= 0;
      last <= 24'h000000;
      o_done <= 1'b0;
    end else begin
      o_done <= (cnt == 1);
      if (i_start) begin
        cnt <= DLY;
        last <= i_press;
      end else if (cnt > 0) begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule
`default_nettype wire

// ==== verif/bctr_regs_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module bctr_regs_tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [6:0] addr = 7'h00;
  logic [7:0] wdata = 8'h00;
  logic [23:0] press_nx = 24'h000000;
  logic [7:0] rdata;
  logic start;
  logic done;
  logic [23:0] mpress;
  logic [15:0] mtemp;
  logic irq;
  logic pd;
  logic tw;
  logic [4:0] bw;
  int num_errors = 0;
  int checks = 0;
  int cyc[6] = '{0, 100, 50, 30, 20, 10};
  logic [6:0] rw[5] = '{7'h0b, 7'h0c, 7'h0d, 7'h10, 7'h11};
  logic [7:0] wm[4] = '{8'haf, 8'hff, 8'hff, 8'h7f};
  logic [7:0] cf[4] = '{8'h0b, 8'h09, 8'h0a, 8'h03};
  logic [6:0] q_adr[$];
  logic [7:0] q_exp[$];
  logic [23:0] p;
  logic [15:0] thr;
  logic [7:0] v;
  logic [7:0] o;
  logic hi;
  logic lo;
  int lim;
  int r;
  int n;
  int mv[5];

  bctr_regs #(.CYC_1(100), .CYC_10(50), .CYC_25(30), .CYC_50(20),
    .CYC_75(10)) dut_u (
    .i_mclk(clk), .i_rst_n(rst_n), .i_reg_wr(wr), .i_reg_rd(rd),
    .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
    .o_conv_start(start), .i_conv_done(done), .i_meas_pressure(mpress),
    .i_meas_temp(mtemp), .o_irq_request(irq), .o_power_down(pd),
    .o_three_wire_select(tw), .o_bandwidth_div(bw));
  bctr_sense_model sense_u (
    .i_mclk(clk), .i_rst_n(rst_n), .i_start(start), .i_press(press_nx),
    .o_done(done), .o_press(mpress), .o_temp(mtemp));

  initial begin
    forever #50 clk = ~clk;
  end

  task automatic chk(input logic [23:0] g, input logic [23:0] e);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr_reg(input logic [6:0] a, input logic [7:0] d);
    @(negedge clk);
    wr = 1'b1;
    addr = a;
    wdata = d;
    @(negedge clk);
    wr = 1'b0;
  endtask
  task automatic rd_reg(input logic [6:0] a, output logic [7:0] d);
    @(negedge clk);
    rd = 1'b1;
    addr = a;
    @(negedge clk);
    rd = 1'b0;
    d = rdata;
  endtask
  task automatic rd_chk(input logic [6:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd_reg(a, d);
    chk({16'h0, d}, {16'h0, e});
  endtask
  task automatic rd3_chk(input logic [6:0] a, input logic [23:0] e);
    logic [23:0] q;
    rd_reg(a, q[7:0]);
    rd_reg(a + 7'h01, q[15:8]);
    rd_reg(a + 7'h02, q[23:16]);
    chk(q, e);
  endtask
  task automatic shot(input logic [23:0] pv);
    int m;
    press_nx = pv;
    wr_reg(bctr_pkg::A_CTRL2, 8'h01);
    m = 0;
    while (!done && m < 50) begin
      @(negedge clk);
      m++;
    end
    repeat (4) @(negedge clk);
  endtask
  task automatic shot_chk(input logic [23:0] pv, input logic [23:0] e);
    shot(pv);
    rd3_chk(bctr_pkg::A_P_XL, e);
  endtask
  task automatic wait_start(output int m);
    m = 0;
    do begin
      @(negedge clk);
      m++;
    end while (!start && m < 300);
  endtask
  task automatic tend(input string s);
    $display("test %s finished", s);
  endtask
  task automatic end_of_test();
    $display("checks=%0d num_errors=%0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Generous bound on the whole sequence
  initial begin
    #2_000_000;
    num_errors++;
    end_of_test();
  end

  initial begin
    void'($urandom(32'h2537));
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    foreach (rw[i]) rd_chk(rw[i], 8'h00);
    chk({17'h0, pd, tw, bw}, 24'h000042);
    wr_reg(bctr_pkg::A_WHO, 8'hff);
    wr_reg(7'h0e, 8'hff);
    rd_chk(bctr_pkg::A_WHO, bctr_pkg::ID_DEFAULT);
    rd_chk(7'h0e, 8'h00);
    rd_chk(7'($urandom % 11), 8'h00);
    tend("reset");
    // Ctrl1 kept at rate zero so nothing starts yet
    // host keeps bit seven clear
    for (int i = 0; i < 4; i++) begin
      v = 8'($urandom) & (i == 3 ? 8'h0f : 8'hff);
      wr_reg(rw[i], v);
      q_adr.push_back(rw[i]);
      q_exp.push_back(v & wm[i]);
    end
    while (q_adr.size() > 0) begin
      rd_chk(q_adr.pop_front(), q_exp.pop_front());
    end
    for (int k = 0; k < 8; k++) begin
      wr_reg(bctr_pkg::A_CTRL1, {4'h0, k[1:0], 1'b0, k[2]});
      @(negedge clk);
      chk({18'h0, tw, bw}, {18'h0, k[2], k[1] ? (k[0] ? 5'h14 :
        5'h09) : 5'h02});
    end
    tend("config");
    thr = (16'($urandom) & 16'h3fff) | 16'h0001;
    lim = int'(thr) << 8;
    mv = '{lim + 1, -lim - 1, lim, -lim, 0};
    wr_reg(bctr_pkg::A_THS_L, thr[7:0]);
    wr_reg(bctr_pkg::A_THS_H, thr[15:8]);
    foreach (cf[i]) begin
      wr_reg(bctr_pkg::A_INT_CFG, cf[i]);
      foreach (mv[j]) begin
        shot(24'(mv[j]));
        hi = cf[i][3] && cf[i][0] && mv[j] > lim;
        lo = cf[i][3] && cf[i][1] && mv[j] < -lim;
        chk({23'h0, irq}, {23'h0, hi | lo});
        rd_chk(bctr_pkg::A_INT_SRC, {5'h0, hi | lo, lo, hi});
        rd3_chk(bctr_pkg::A_P_XL, 24'(mv[j]));
      end
    end
    rd_chk(bctr_pkg::A_CTRL2, 8'h00);
    wr_reg(bctr_pkg::A_INT_CFG, 8'h0f);
    shot(24'(lim + 1));
    shot(24'h000000);
    chk({23'h0, irq}, 24'h000001);
    rd_chk(bctr_pkg::A_INT_SRC, 8'h05);
    @(negedge clk);
    chk({23'h0, irq}, 24'h000000);
    tend("threshold");
    r = int'($urandom & 32'h0007ffff) | 32'h00080000;
    wr_reg(bctr_pkg::A_INT_CFG, 8'h20);
    shot_chk(24'(r), 24'h000000);
    rd_chk(bctr_pkg::A_INT_CFG, 8'h00);
    rd3_chk(bctr_pkg::A_REF_XL, 24'(r));
    shot_chk(24'(r + 256), 24'h000100);
    wr_reg(bctr_pkg::A_INT_CFG, 8'h10);
    rd3_chk(bctr_pkg::A_REF_XL, 24'h000000);
    shot_chk(24'(r), 24'(r));
    o = 8'($urandom);
    wr_reg(bctr_pkg::A_OFS_L, o);
    wr_reg(bctr_pkg::A_OFS_H, 8'h00);
    wr_reg(bctr_pkg::A_INT_CFG, 8'h80);
    shot_chk(24'(r), 24'(r - o));
    rd_chk(bctr_pkg::A_INT_CFG, 8'h00);
    rd3_chk(bctr_pkg::A_REF_XL, 24'(r));
    wr_reg(bctr_pkg::A_INT_CFG, 8'h0b);
    shot_chk(24'(r - lim - 1), 24'(r - lim - 1 - o));
    rd_chk(bctr_pkg::A_INT_SRC, 8'h06);
    wr_reg(bctr_pkg::A_INT_CFG, 8'h40);
    shot_chk(24'(r), 24'(r));
    tend("reference");
    wr_reg(bctr_pkg::A_CTRL1, 8'h02);
    shot(24'h000111);
    shot(24'h000222);
    rd3_chk(bctr_pkg::A_P_XL, 24'h000111);
    shot_chk(24'h000333, 24'h000333);
    tend("freeze");
    wr_reg(bctr_pkg::A_CTRL1, 8'h00);
    press_nx = 24'($urandom);
    for (int c = 1; c < 6; c++) begin
      wr_reg(bctr_pkg::A_CTRL1, 8'(c << 4));
      repeat (3) wait_start(n);
      chk(24'(n), 24'(cyc[c]));
    end
    wr_reg(bctr_pkg::A_CTRL1, 8'h00);
    repeat (10) @(negedge clk);
    chk({23'h0, pd}, 24'h000001);
    rd3_chk(bctr_pkg::A_P_XL, press_nx);
    repeat (200) @(negedge clk);
    rd3_chk(bctr_pkg::A_P_XL, press_nx);
    tend("rates");
    end_of_test();
  end
endmodule
`default_nettype wire
